// [periodic_timer_supervisor.sv]
// Purpose: Prescaler, auto-reload tick timer and 8-bit supervision counter with AXI4-Lite registers
// Assumes: lf_clk, alt_clk and selects are synchronous to aclk; counting runs on lf_clk rising edges, supervision on alt_clk ones while alt_clk_select is high
// Notes:   Operation
// Operation
// - Prescaler divides input by two to exponent
// - Tick counter counts preset down, then reloads
// - Tick output high one prescaled cycle at zero
// - New preset used only at next reload
// - Restart bit reloads counter, clears itself
// - Supervision counter idle after reset
// - First count or match write starts it
// - Unlocked count write loads and restarts
// - Key write reloads, other data fails
// - Counter reaching zero raises failure
// - Double service in one period fails
// - Clock select bit, hardware select overrides
// - Match writes ignored while match disabled
// - Lock bits block writes, sticky until reset
// - Tick lock blocks preset and control writes
// - Configuration resets to all zero
// - Prescaler divide field low bits, resets zero
// - Writes take effect within three cycles
// - Counters run in idle, accesses wait
// - Divide zero may skip one count
// - Clock source change may slip one
// - Terminal count flag, cleared on read
// - Tick preset resets to all ones
// - Supervision count resets to 0Fh
`timescale 1ns/10ps
module periodic_timer_supervisor
  import periodic_timer_pkg::*;
#(
  parameter int TICK_W = 16,
  parameter int SUPV_W = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        lf_clk,
  input  wire logic        alt_clk,
  input  wire logic        alt_clk_select,
  input  wire logic        system_idle,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             tick_output,
  output logic             supervision_fail
);

  // Address decode shared by the read and write paths
  function automatic reg_sel_t decode(input logic [7:0] addr);
    unique case (addr)
      OFS_CONFIG:      decode = REG_CONFIG;
      OFS_PRESCALER:   decode = REG_PRESCALER;
      OFS_TICK_PRESET: decode = REG_TICK_PRESET;
      OFS_TICK_CTRL:   decode = REG_TICK_CTRL;
      OFS_SUPV_COUNT:  decode = REG_SUPV_COUNT;
      OFS_SERVICE:     decode = REG_SERVICE;
      default:         decode = REG_NONE;
    endcase
  endfunction

  config_t           cfg;
  logic [DIV_W-1:0]  divide_exponent;
  logic [TICK_W-1:0] tick_preset;
  logic [TICK_W-1:0] tick_cnt;
  logic              tick_restart;
  logic              terminal_count_flag;
  logic [SUPV_W-1:0] supervision_count;
  logic [SUPV_W-1:0] supv_cnt;
  logic              supv_running;
  logic              serviced;
  logic [4:0]        div_cnt;
  logic              lf_prev;
  logic              alt_prev;

  // AXI write channel holding registers
  logic              aw_full;
  logic              w_full;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;

  logic              aw_take;
  logic              w_take;
  logic              wr_do;
  logic              ar_take;
  reg_sel_t          wr_sel;
  reg_sel_t          rd_sel;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_do   = aw_full && w_full && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_sel  = decode(aw_addr);
  assign rd_sel  = decode(s_axi_araddr);

  // Write strobes that hit each register, already filtered by locks or, for the service register, by the match enable
  logic wr_cfg;
  logic wr_div;
  logic wr_preset;
  logic wr_ctrl;
  logic wr_count;
  logic wr_match;
  assign wr_cfg    = wr_do && wr_sel == REG_CONFIG && w_strb[0] && !cfg.config_lock;
  assign wr_div    = wr_do && wr_sel == REG_PRESCALER && w_strb[0] && !cfg.prescaler_lock;
  assign wr_preset = wr_do && wr_sel == REG_TICK_PRESET && !cfg.tick_lock;
  assign wr_ctrl   = wr_do && wr_sel == REG_TICK_CTRL && w_strb[0] && !cfg.tick_lock;
  assign wr_count  = wr_do && wr_sel == REG_SUPV_COUNT && w_strb[0] && !cfg.count_lock;
  assign wr_match  = wr_do && wr_sel == REG_SERVICE && w_strb[0] && cfg.data_match_enable;

  // Bus handshakes pause while the system idles; counters keep going regardless
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_full       <= (aw_full || aw_take) && !wr_do;
      w_full        <= (w_full || w_take) && !wr_do;
      s_axi_awready <= !((aw_full || aw_take) && !wr_do) && !system_idle;
      s_axi_wready  <= !((w_full || w_take) && !wr_do) && !system_idle;
    end
  end

  // Write response follows once both address and data are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path; locked config, prescaler and preset registers and write-only registers read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready)) && !system_idle;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (rd_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        unique case (rd_sel)
          REG_CONFIG:      s_axi_rdata[5:0] <= cfg.config_lock ? 6'h00 : cfg;
          REG_PRESCALER:   s_axi_rdata[DIV_W-1:0] <= cfg.prescaler_lock ? DIV_RST : divide_exponent;
          REG_TICK_PRESET: s_axi_rdata[TICK_W-1:0] <= cfg.tick_lock ? '0 : tick_preset;
          REG_TICK_CTRL: begin
            s_axi_rdata[TCS_TC_BIT]      <= terminal_count_flag;
            s_axi_rdata[TCS_RESTART_BIT] <= tick_restart;
          end
          REG_SUPV_COUNT,
          REG_SERVICE,
          REG_NONE:        s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Configuration: lock bits can only be set, the rest follow writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= CONFIG_RST;
    end else if (wr_cfg) begin
      cfg.config_lock              <= 1'b1 & (cfg.config_lock | w_data[0]);
      cfg.prescaler_lock           <= cfg.prescaler_lock | w_data[1];
      cfg.tick_lock                <= cfg.tick_lock | w_data[2];
      cfg.count_lock               <= cfg.count_lock | w_data[3];
      cfg.supervision_clock_select <= w_data[4];
      cfg.data_match_enable        <= w_data[5];
    end
  end

  // Prescaler and preset stores; writes land at once, well inside the allowed latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divide_exponent <= DIV_RST;
      tick_preset     <= TICK_PRESET_RST;
    end else begin
      if (wr_div) begin
        divide_exponent <= w_data[DIV_W-1:0];
      end
      if (wr_preset && w_strb[0]) begin
        tick_preset[7:0] <= w_data[7:0];
      end
      if (wr_preset && w_strb[1]) begin
        tick_preset[15:8] <= w_data[15:8];
      end
    end
  end

  // Prescaler: reserved codes above five behave as the slowest ratio
  logic [2:0] eff_div;
  logic [4:0] div_mask;
  logic       lf_rise;
  logic       pre_en;
  assign eff_div  = (divide_exponent > DIV_MAX) ? DIV_MAX : divide_exponent;
  assign div_mask = 5'((6'h01 << eff_div) - 6'h01);
  assign lf_rise  = lf_clk && !lf_prev;
  assign pre_en   = lf_rise && ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_prev  <= 1'b0;
      alt_prev <= 1'b0;
      div_cnt  <= 5'h00;
    end else begin
      lf_prev  <= lf_clk;
      alt_prev <= alt_clk;
      if (lf_rise) begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  // Tick counter; restart and reload both take the preset as it is now
  logic [TICK_W-1:0] next_tick_cnt;
  logic              tick_event;
  always_comb begin
    next_tick_cnt = tick_cnt;
    if (tick_restart || tick_cnt == '0) begin
      next_tick_cnt = tick_preset;
    end else begin
      next_tick_cnt = tick_cnt - 1'b1;
    end
  end
  // Rising edge of the tick output, used as the slow supervision clock
  assign tick_event = pre_en && next_tick_cnt == '0 && !tick_output;

  // With divide zero a reload may land one count short; accepted behaviour
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt     <= TICK_PRESET_RST;
      tick_output  <= 1'b0;
      tick_restart <= 1'b0;
    end else begin
      if (pre_en) begin
        tick_cnt    <= next_tick_cnt;
        tick_output <= next_tick_cnt == '0;
      end
      if (wr_ctrl && w_data[TCS_RESTART_BIT]) begin
        tick_restart <= 1'b1;
      end else if (pre_en) begin
        tick_restart <= 1'b0;
      end
    end
  end

  // Terminal count flag; a new event wins over the read that clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      terminal_count_flag <= 1'b0;
    end else if (tick_event) begin
      terminal_count_flag <= 1'b1;
    end else if (ar_take && rd_sel == REG_TICK_CTRL) begin
      terminal_count_flag <= 1'b0;
    end
  end

  // Supervision clock; a source switch may gain or lose one edge
  logic supv_en;
  always_comb begin
    if (alt_clk_select) begin
      supv_en = alt_clk && !alt_prev;
    end else if (cfg.supervision_clock_select) begin
      supv_en = pre_en;
    end else begin
      supv_en = tick_event;
    end
  end

  // Service sources and failure causes
  logic service;
  logic bad_key;
  logic too_early;
  logic too_late;
  logic fault_now;
  assign service   = wr_count || (wr_match && w_data[7:0] == SERVICE_KEY);
  assign bad_key   = wr_match && w_data[7:0] != SERVICE_KEY;
  assign too_early = service && serviced;
  assign too_late  = supv_en && supv_running && !service && supv_cnt <= 8'h01;
  assign fault_now = bad_key || too_early || too_late;

  // Supervision counter; idle after reset, only reset stops it once started
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supervision_count <= SUPV_COUNT_RST;
      supv_cnt          <= SUPV_COUNT_RST;
      supv_running      <= 1'b0;
      serviced          <= 1'b0;
    end else begin
      if (wr_count) begin
        supervision_count <= w_data[7:0];
        supv_cnt          <= w_data[7:0];
      end else if (service) begin
        supv_cnt <= supervision_count;
      end else if (too_late) begin
        supv_cnt <= supervision_count;
      end else if (supv_en && supv_running) begin
        supv_cnt <= supv_cnt - 1'b1;
      end
      if (wr_count || wr_match) begin
        supv_running <= 1'b1;
      end
      if (service) begin
        serviced <= 1'b1;
      end else if (supv_en) begin
        serviced <= 1'b0;
      end
    end
  end

  // Failure is a single aclk pulse for the reset logic to catch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supervision_fail <= 1'b0;
    end else begin
      supervision_fail <= fault_now;
    end
  end

  // Checks
  sequence key_write_s;
    wr_match && w_data[7:0] == SERVICE_KEY && !wr_count;
  endsequence

  sequence bad_write_s;
    wr_match && w_data[7:0] != SERVICE_KEY;
  endsequence

  // A second high cycle is only allowed when a new cause arrived meanwhile
  sequence fail_pulse_s;
    supervision_fail ##1 (!supervision_fail || $past(fault_now));
  endsequence

  prescale_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_en && eff_div == 3'h5 |-> div_cnt[4:0] == 5'h1F)
    else $error("prescaled edge off its divide point");

  tick_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_en && tick_cnt == '0 |=> tick_cnt == $past(tick_preset))
    else $error("tick counter did not reload preset");

  tick_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tick_output) |-> tick_cnt == '0 ##1 (tick_output || $past(pre_en)))
    else $error("tick output not tied to zero count");

  restart_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_restart && pre_en && !wr_ctrl |=> !tick_restart && tick_cnt == $past(tick_preset))
    else $error("restart bit not consumed");

  idle_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !supv_running && !wr_do |=> !supervision_fail)
    else $error("failure before supervision started");

  lock_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.config_lock |=> cfg.config_lock && $stable(cfg))
    else $error("locked configuration changed");

  key_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    key_write_s |=> supv_cnt == $past(supervision_count) && supv_running)
    else $error("key write did not reload counter");

  bad_key_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bad_write_s |=> fail_pulse_s)
    else $error("bad key did not raise one failure pulse");

  too_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
    too_late |=> supervision_fail && supv_cnt == $past(supervision_count))
    else $error("expiry did not raise failure");

  tc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && rd_sel == REG_TICK_CTRL && !tick_event |=> !terminal_count_flag)
    else $error("terminal count flag survived read");

  idle_bus_a: assert property (@(posedge aclk) disable iff (!aresetn)
    system_idle [*2] |-> !s_axi_arready && !s_axi_awready)
    else $error("bus accepted access during idle");

endmodule

// [periodic_timer_pkg.sv]
// Purpose: Shared constants and types for the periodic tick and supervision block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   Narrow registers sit in the low bits, upper bits read as zero
package periodic_timer_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG       = 8'h00;
  localparam logic [7:0] OFS_PRESCALER    = 8'h04;
  localparam logic [7:0] OFS_TICK_PRESET  = 8'h08;
  localparam logic [7:0] OFS_TICK_CTRL    = 8'h0C;
  localparam logic [7:0] OFS_SUPV_COUNT   = 8'h10;
  localparam logic [7:0] OFS_SERVICE      = 8'h14;
  // Field positions in the tick control register
  localparam int         TCS_RESTART_BIT  = 0;
  localparam int         TCS_TC_BIT       = 1;
  // Field width of the divide exponent and its largest legal code
  localparam int         DIV_W            = 3;
  localparam logic [2:0] DIV_MAX          = 3'h5;
  // Reset values
  localparam logic [15:0] TICK_PRESET_RST = 16'hFFFF;
  localparam logic [7:0]  SUPV_COUNT_RST  = 8'h0F;
  localparam logic [2:0]  DIV_RST         = 3'h0;
  // Service key that reloads the supervision counter
  localparam logic [7:0]  SERVICE_KEY     = 8'h5C;
  // Low-frequency input rate and the latency bound for register writes
  localparam int          LF_CLK_HZ       = 32768;
  localparam int          WRITE_DELAY_LF  = 3;
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // Configuration register, bits 5..0; bits 7..6 reserved
  typedef struct packed {
    logic data_match_enable;
    logic supervision_clock_select;
    logic count_lock;
    logic tick_lock;
    logic prescaler_lock;
    logic config_lock;
  } config_t;

  localparam config_t CONFIG_RST = '0;

  typedef enum logic [2:0] {
    REG_CONFIG,
    REG_PRESCALER,
    REG_TICK_PRESET,
    REG_TICK_CTRL,
    REG_SUPV_COUNT,
    REG_SERVICE,
    REG_NONE
  } reg_sel_t;
endpackage

// [low_freq_source.sv]
// Purpose: Low-frequency and alternate clock source facing the timer block
// Assumes: Both clocks are made synchronous to aclk, since the block samples them
// Notes:   Rates are far above 32.768 kHz so that the run stays short
`timescale 1ns/10ps
module low_freq_source (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      lf_clk,
  output logic      alt_clk
);
  logic [3:0] div_cnt;

  // One lf period is 8 aclk, alt runs four times slower; both stop in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 4'h0;
      lf_clk  <= 1'b0;
      alt_clk <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      if (div_cnt[1:0] == 2'h3) lf_clk <= !lf_clk;
      if (div_cnt == 4'hF) alt_clk <= !alt_clk;
    end
  end
endmodule

// [periodic_timer_supervisor_tb.sv]
// Purpose: Self-checking bench for the periodic tick and supervision block
// Assumes: One prescaled cycle is 8 aclk shifted left by the divide field
// Notes:   Failure pulses are counted, tick periods timed at falling edges
`timescale 1ns/10ps
module periodic_timer_supervisor_tb
  import periodic_timer_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  localparam int LIMIT = 30000;
  logic        aclk, aresetn, lf_clk, alt_clk, alt_clk_select, system_idle, tick_output, supervision_fail;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, last_tick;
  int          miscompares = 0, comparisons = 0, cycles = 0, fails = 0, t0, t1, t2;
  // Reset image of the map, unmapped place last
  row_t        rows [6] = '{'{OFS_CONFIG, 32'h0, RESP_OKAY}, '{OFS_PRESCALER, 32'h0, RESP_OKAY},
                            '{OFS_TICK_PRESET, 32'hFFFF, RESP_OKAY}, '{OFS_TICK_CTRL, 32'h0, RESP_OKAY},
                            '{OFS_SUPV_COUNT, 32'h0, RESP_OKAY}, '{8'h18, 32'h0, RESP_DECERR}};

  low_freq_source i_src (.aclk, .aresetn, .lf_clk, .alt_clk);

  periodic_timer_supervisor i_dut (.aclk, .aresetn, .lf_clk, .alt_clk, .alt_clk_select, .system_idle,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tick_output,
    .supervision_fail);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Failure pulses last one aclk, so a counter is the only safe way to see them
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (supervision_fail === 1'b1) fails <= fails + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  always @(negedge aclk) last_tick <= tick_output;

  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken; only the cycle ceiling ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Timestamp of the next rising tick; stable levels are seen at falling edges
  task automatic wait_tick(output int t);
    do begin
      @(negedge aclk);
    end while (!(tick_output === 1'b1 && last_tick === 1'b0));
    t = cycles;
  endtask

  task automatic run_rows();
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk("read response", {30'h0, r}, {30'h0, rows[i].r});
      if (rows[i].r == RESP_OKAY) chk("reset value", d, rows[i].d);
    end
  endtask

  initial begin
    aresetn = 1'b0;
    system_idle = 1'b0; // idle only long after start-up and after the locked writes, before the reset and the slowest-ratio writes
    alt_clk_select = 1'b0;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    run_rows();
    // Idle supervisor must ignore a wrong key while matching is off
    wr(OFS_SERVICE, 32'h33);
    wr(8'h18, 32'h1);
    chk("unmapped write", {30'h0, r}, {30'h0, RESP_DECERR});
    repeat (40) @(posedge aclk);
    chk("idle failures", 32'(fails), 32'h0);
    // Tick clock is very slow here, so two keys always share one period
    wr(OFS_CONFIG, 32'h20);
    wr(OFS_SERVICE, {24'h0, SERVICE_KEY});
    repeat (20) @(posedge aclk);
    chk("key service", 32'(fails), 32'h0);
    wr(OFS_SERVICE, {24'h0, SERVICE_KEY});
    repeat (4) @(posedge aclk);
    chk("early service", 32'(fails), 32'h1);
    wr(OFS_SERVICE, 32'h33);
    repeat (4) @(posedge aclk);
    chk("wrong key", 32'(fails), 32'h2);
    wr(OFS_CONFIG, 32'h30);
    // Let a prescaled edge close the key period first, so this service is not early
    repeat (16) @(posedge aclk);
    t0 = fails;
    wr(OFS_SUPV_COUNT, 32'h2);
    repeat (40) @(posedge aclk);
    chk("late service", 32'(fails > t0), 32'h1);
    // Hardware select beats the config bit: expiries slow from every 16 to every 64 cycles
    alt_clk_select <= 1'b1;
    repeat (40) @(posedge aclk);
    t0 = fails;
    repeat (128) @(posedge aclk);
    chk("alt clock expiries", 32'(fails - t0 inside {[1:3]}), 32'h1);
    alt_clk_select <= 1'b0;
    // Divide by two avoids the allowed skipped count at divide zero
    wr(OFS_PRESCALER, 32'h1);
    wr(OFS_TICK_PRESET, 32'h3);
    wr(OFS_TICK_CTRL, 32'h1);
    wait_tick(t0);
    wait_tick(t1);
    chk("tick period", 32'(t1 - t0), 32'h40);
    rd(OFS_TICK_CTRL);
    chk("tick status", d, 32'h2);
    repeat (20) @(posedge aclk);
    rd(OFS_TICK_CTRL);
    chk("status cleared", d, 32'h0);
    wr(OFS_TICK_PRESET, 32'h7);
    wait_tick(t2);
    chk("preset deferred", 32'(t2 - t1), 32'h40);
    wait_tick(t0);
    chk("new preset", 32'(t0 - t2), 32'h80);
    // Locked writes must leave the running period untouched
    wr(OFS_CONFIG, 32'h0F);
    wr(OFS_PRESCALER, 32'h0);
    wr(OFS_TICK_PRESET, 32'h1);
    wr(OFS_CONFIG, 32'h0);
    // Idle stalls the bus but the tick keeps its period
    system_idle <= 1'b1;
    wait_tick(t1);
    wait_tick(t2);
    chk("locked period", 32'(t2 - t1), 32'h80);
    chk("idle readies", 32'({s_axi_arready, s_axi_awready, s_axi_wready}), 32'h0);
    @(posedge aclk);
    system_idle <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    run_rows();
    // A key alone starts the counter from the reset count of 15 prescaled edges
    wr(OFS_CONFIG, 32'h30);
    t0 = fails;
    wr(OFS_SERVICE, {24'h0, SERVICE_KEY});
    repeat (90) @(posedge aclk);
    chk("reset count early", 32'(fails - t0), 32'h0);
    repeat (50) @(posedge aclk);
    chk("reset count expiry", 32'(fails - t0), 32'h1);
    // Slowest ratio: 32 lf periods per prescaled edge, preset 1 gives two edges a tick
    wr(OFS_PRESCALER, 32'h5);
    wr(OFS_TICK_PRESET, 32'h1);
    wr(OFS_TICK_CTRL, 32'h1);
    wait_tick(t0);
    wait_tick(t1);
    chk("slowest ratio", 32'(t1 - t0), 32'h200);
    end_sim();
  end
endmodule
